/* inc/sdac_pkg.sv */
// shared constants and types for the sigma-delta converter control block
package sdac_pkg;

  // clocking and sampling
  localparam int CLK_HZ = 20_000_000;
  localparam int SAMPLE_HZ = 1_000_000;
  localparam int DIV_CYC = CLK_HZ / SAMPLE_HZ;
  localparam logic [4:0] DIV_LAST = 5'(DIV_CYC - 1);

  // conversion period at rate code 0, in microseconds
  localparam int BASE_US = 32;
  localparam int BASE_SAMPLES = BASE_US * SAMPLE_HZ / 1_000_000;
  localparam int CNT_W = 13;
  localparam int BASE_BITS = 5;
  localparam int RES_W = 16;
  localparam logic [3:0] TOP_SHIFT = 4'(RES_W - BASE_BITS);

  // register indices; byte address is four times the index
  localparam int ADDR_W = 17;
  localparam logic [14:0] IDX_DATA = 15'h4900;
  localparam logic [14:0] IDX_CFG = 15'h4902;
  localparam logic [14:0] IDX_FLAG = 15'h4904;
  localparam logic [14:0] IDX_MASK = 15'h4906;

  // configuration field positions
  localparam int CFG_RUN = 0;
  localparam int CFG_DITH = 1;
  localparam int CFG_SEL_LO = 8;
  localparam int CFG_RATE_LO = 12;
  localparam int FLAG_DONE = 0;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // input select codes
  localparam logic [3:0] SEL_IN0 = 4'h0;
  localparam logic [3:0] SEL_IN1 = 4'h1;
  localparam logic [3:0] SEL_IN2 = 4'h2;
  localparam logic [3:0] SEL_IN3 = 4'h3;
  localparam logic [3:0] SEL_PAD = 4'h4;
  localparam logic [3:0] SEL_CORE = 4'h5;
  localparam logic [3:0] SEL_GND = 4'h7;
  localparam logic [3:0] SEL_VREF = 4'h8;
  localparam logic [3:0] SEL_DIFF01 = 4'h9;
  localparam logic [3:0] SEL_DIFF23 = 4'hA;

  // positive and negative legs of the differential input stage
  typedef enum logic [3:0] {
    POS_IN0, POS_IN1, POS_IN2, POS_IN3, POS_PAD_QTR,
    POS_CORE_HALF, POS_GND, POS_VREF, POS_NONE
  } sdac_pos_e;

  typedef enum logic [1:0] {
    NEG_HALF_VREF, NEG_IN1, NEG_IN3, NEG_NONE
  } sdac_neg_e;

  typedef struct packed {
    sdac_pos_e pos;
    sdac_neg_e neg;
  } sdac_mux_s;

endpackage : sdac_pkg

/* rtl/sdac_decim.sv */
// decimator: counts modulator ones over one conversion period
`timescale 1ns/1ps
module sdac_decim (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] rate,
  input wire logic tick,
  input wire logic mod_bit,
  output logic done,
  output logic [15:0] result
);

  typedef struct packed {
    logic [sdac_pkg::CNT_W-1:0] cnt;
    logic [sdac_pkg::CNT_W-1:0] ones;
    logic done;
    logic [15:0] result;
  } sdac_dec_s;

  sdac_dec_s st_q;
  sdac_dec_s st_d;
  logic [sdac_pkg::CNT_W-1:0] target;
  logic [sdac_pkg::CNT_W-1:0] full;
  logic [sdac_pkg::CNT_W-1:0] sum;
  logic [sdac_pkg::CNT_W-1:0] sat;

  // period in samples doubles per rate code
  assign target = sdac_pkg::CNT_W'(sdac_pkg::BASE_SAMPLES) << rate;
  // shift amount kept four bits wide: base width plus rate code reaches 12
  assign full = sdac_pkg::CNT_W'(1) << (4'(sdac_pkg::BASE_BITS) + 4'(rate));
  assign sum = st_q.ones + sdac_pkg::CNT_W'(mod_bit);
  // all-ones input would overflow the field by one, so clip it
  assign sat = (sum >= full) ? full - 13'h0001 : sum;

  // accumulate at each 1 MHz tick, close out at the period end
  always_comb
  begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (!run)
    begin
      st_d.cnt = '0;
      st_d.ones = '0;
    end
    else if (tick)
    begin
      if (st_q.cnt == target - 13'h0001)
      begin
        st_d.done = 1'b1;
        st_d.result = 16'({3'h0, sat} << (sdac_pkg::TOP_SHIFT - 4'(rate)));
        st_d.cnt = '0;
        st_d.ones = '0;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 13'h0001;
        st_d.ones = sum;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign done = st_q.done;
  assign result = st_q.result;

  AST_DONE_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
    done |=> !done) else $error("done pulse longer than one cycle");
  AST_RES_ALIGN: assert property (@(posedge aclk) disable iff (!aresetn)
    done |-> ((result & ~(16'hFFFF << (sdac_pkg::TOP_SHIFT - 4'(rate)))) == 16'h0000))
    else $error("result not left aligned");
  AST_RES_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_d.done |=> $stable(result)) else $error("result changed without done");

endmodule : sdac_decim

/* rtl/sdac_top.sv */
// sigma-delta converter control with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sdac_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [16:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [16:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mod_bit,
  output sdac_pkg::sdac_mux_s mux,
  output logic dither_off,
  output logic vref_out_en,
  output logic conv_run,
  output logic irq
);

  typedef struct packed {
    logic aw_have;
    logic [sdac_pkg::ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic run;
    logic dith_off;
    logic [3:0] sel;
    logic [2:0] rate;
    logic flag;
    logic mask;
    logic [4:0] div;
    logic tick;
    logic mod_s1;
    logic mod_s2;
    sdac_pkg::sdac_mux_s mux;
  } sdac_state_s;

  sdac_state_s st_q;
  sdac_state_s st_d;
  logic done;
  logic [15:0] result;
  logic wr_fire;
  logic wr_cfg;
  logic wr_flag;
  logic wr_mask;
  logic wr_data;
  logic flag_clr;
  logic rd_take;
  logic [sdac_pkg::ADDR_W-1:0] raddr;

  // word index match; bits below the word are ignored
  function automatic logic reg_hit(
    input logic [sdac_pkg::ADDR_W-1:0] addr,
    input logic [14:0] idx
  );
    reg_hit = (addr[sdac_pkg::ADDR_W-1:2] == idx);
  endfunction : reg_hit

  // input routing for both legs of the differential stage
  function automatic sdac_pkg::sdac_mux_s sel_decode(input logic [3:0] sel);
    sdac_pkg::sdac_mux_s m;
    m.pos = sdac_pkg::POS_NONE;
    m.neg = sdac_pkg::NEG_HALF_VREF;
    case (sel)
      sdac_pkg::SEL_IN0: m.pos = sdac_pkg::POS_IN0;
      sdac_pkg::SEL_IN1: m.pos = sdac_pkg::POS_IN1;
      sdac_pkg::SEL_IN2: m.pos = sdac_pkg::POS_IN2;
      sdac_pkg::SEL_IN3: m.pos = sdac_pkg::POS_IN3;
      sdac_pkg::SEL_PAD: m.pos = sdac_pkg::POS_PAD_QTR;
      sdac_pkg::SEL_CORE: m.pos = sdac_pkg::POS_CORE_HALF;
      sdac_pkg::SEL_GND: m.pos = sdac_pkg::POS_GND;
      sdac_pkg::SEL_VREF: m.pos = sdac_pkg::POS_VREF;
      sdac_pkg::SEL_DIFF01:
      begin
        m.pos = sdac_pkg::POS_IN0;
        m.neg = sdac_pkg::NEG_IN1;
      end
      sdac_pkg::SEL_DIFF23:
      begin
        m.pos = sdac_pkg::POS_IN2;
        m.neg = sdac_pkg::NEG_IN3;
      end
      // reserved codes leave the stage unconnected
      default: m.neg = sdac_pkg::NEG_NONE;
    endcase
    sel_decode = m;
  endfunction : sel_decode

  // ready terms: one write and one read in flight at most
  assign s_axi_awready = !st_q.aw_have && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_have && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign wr_fire = st_q.aw_have && st_q.w_have && !st_q.bvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign raddr = s_axi_araddr;

  // write decode of the held address
  assign wr_cfg = wr_fire && reg_hit(st_q.awaddr, sdac_pkg::IDX_CFG);
  assign wr_flag = wr_fire && reg_hit(st_q.awaddr, sdac_pkg::IDX_FLAG);
  assign wr_mask = wr_fire && reg_hit(st_q.awaddr, sdac_pkg::IDX_MASK);
  assign wr_data = wr_fire && reg_hit(st_q.awaddr, sdac_pkg::IDX_DATA);
  assign flag_clr = wr_flag && st_q.wstrb[0] && st_q.wdata[sdac_pkg::FLAG_DONE];

  // next-state logic for bus, configuration, flag and sampling
  always_comb
  begin
    st_d = st_q;

    // address and data are caught independently, in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_d.w_have = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;
    if (wr_fire)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = (wr_cfg || wr_flag || wr_mask || wr_data) ?
        sdac_pkg::RESP_OKAY : sdac_pkg::RESP_SLVERR;
    end

    // configuration writes, byte lanes honoured
    if (wr_cfg && st_q.wstrb[0])
    begin
      st_d.run = st_q.wdata[sdac_pkg::CFG_RUN];
      st_d.dith_off = st_q.wdata[sdac_pkg::CFG_DITH];
    end
    if (wr_cfg && st_q.wstrb[1])
    begin
      st_d.sel = st_q.wdata[sdac_pkg::CFG_SEL_LO +: 4];
      st_d.rate = st_q.wdata[sdac_pkg::CFG_RATE_LO +: 3];
    end
    if (wr_mask && st_q.wstrb[0])
      st_d.mask = st_q.wdata[sdac_pkg::FLAG_DONE];

    // set beats clear so a coinciding completion is never lost
    st_d.flag = (st_q.flag && !flag_clr) || done;

    // registered read answer; the only status bit is the done flag, bit 0 of the flag word
    if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;
    if (rd_take)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp = sdac_pkg::RESP_OKAY;
      st_d.rdata = '0;
      if (reg_hit(raddr, sdac_pkg::IDX_DATA))
        st_d.rdata = {16'h0000, result};
      else if (reg_hit(raddr, sdac_pkg::IDX_CFG))
        st_d.rdata = {17'h00000, st_q.rate, st_q.sel, 6'h00,
          st_q.dith_off, st_q.run};
      else if (reg_hit(raddr, sdac_pkg::IDX_FLAG))
        st_d.rdata = {31'h00000000, st_q.flag};
      else if (reg_hit(raddr, sdac_pkg::IDX_MASK))
        st_d.rdata = {31'h00000000, st_q.mask};
      else
        st_d.rresp = sdac_pkg::RESP_SLVERR;
    end

    // 1 MHz sample tick, restarted whenever run is low
    if (!st_q.run)
    begin
      st_d.div = '0;
      st_d.tick = 1'b0;
    end
    else
    begin
      st_d.tick = (st_q.div == sdac_pkg::DIV_LAST);
      st_d.div = st_d.tick ? 5'h00 : st_q.div + 5'h01;
    end

    // modulator output is asynchronous to aclk
    st_d.mod_s1 = mod_bit;
    st_d.mod_s2 = st_q.mod_s1;

    // routing follows the select field one cycle later
    st_d.mux = sel_decode(st_q.sel);
  end

  // synchronous reset to all zero: run off, select 0, tick idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // period accumulation and result holding
  sdac_decim u_decim (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(st_q.run),
    .rate(st_q.rate),
    .tick(st_q.tick),
    .mod_bit(st_q.mod_s2),
    .done(done),
    .result(result)
  );

  // outputs
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign mux = st_q.mux;
  assign dither_off = st_q.dith_off;
  assign vref_out_en = st_q.run;
  assign conv_run = st_q.run;
  assign irq = st_q.flag && st_q.mask;

  // checks
  AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    done |=> st_q.flag) else $error("completion did not set flag");
  AST_FLAG_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_clr && !done) |=> !st_q.flag) else $error("flag not cleared");
  AST_IRQ_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    irq |-> (st_q.mask && st_q.flag)) else $error("irq without mask and flag");
  AST_VREF: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_cfg && st_q.wstrb[0] && !st_q.wdata[sdac_pkg::CFG_RUN]) |=> !vref_out_en)
    else $error("reference stayed on after stop");
  AST_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_q.run [*2]) |-> !done) else $error("completion while stopped");
  AST_TICK_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.tick |=> (!st_q.tick) [*8]) else $error("ticks too close");
  AST_START: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q.run) |-> ##[1:21] st_q.tick) else $error("no prompt start");
  AST_SE_LEG: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.sel <= sdac_pkg::SEL_IN3) |=> (mux.neg == sdac_pkg::NEG_HALF_VREF))
    else $error("single-ended leg not at half reference");
  AST_DIFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.sel == sdac_pkg::SEL_DIFF01) |=> (mux.pos == sdac_pkg::POS_IN0 &&
    mux.neg == sdac_pkg::NEG_IN1)) else $error("pair 0-1 misrouted");

  COV_DONE: cover property (@(posedge aclk) disable iff (!aresetn)
    done ##1 irq);
  COV_COLLIDE: cover property (@(posedge aclk) disable iff (!aresetn)
    done && flag_clr);
  COV_STOP: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(st_q.run));

endmodule : sdac_top

/* verification/tb_top.sv */
// self-checking bench for the converter control block over its register bus
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, mod_bit;
  logic [16:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  sdac_pkg::sdac_mux_s mux;
  logic dither_off, vref_out_en, conv_run, irq, irq_p;
  logic [31:0] rd;
  int err_total, checks_done, cyc, t_last, gap, rises, r0, mb, per;
  // reference model results, newest at the back
  int res_q[$];
  // byte addresses of the register words
  localparam logic [16:0] A_DATA = 17'h12400;
  localparam logic [16:0] A_CFG = 17'h12408;
  localparam logic [16:0] A_FLAG = 17'h12410;
  localparam logic [16:0] A_MASK = 17'h12418;

  sdac_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mod_bit(mod_bit),
    .mux(mux), .dither_off(dither_off), .vref_out_en(vref_out_en), .conv_run(conv_run),
    .irq(irq)
  );

  // 20 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // completion monitor: spacing between rising edges of the interrupt line
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    irq_p <= irq;
    if (irq === 1'b1 && irq_p === 1'b0)
    begin
      gap <= cyc - t_last;
      t_last <= cyc;
      rises <= rises + 1;
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // a bounded wait that runs out ends the run as a failure
  task automatic hang();
    err_total++;
    final_report();
  endtask : hang

  task automatic axi_wr(input logic [16:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_t = 0;
    w_t = 0;
    b_t = 0;
    n = 0;
    while (!b_t && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (!aw_t && s_axi_awready === 1'b1)
      begin
        aw_t = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_t && s_axi_wready === 1'b1)
      begin
        w_t = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1)
      begin
        b_t = 1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!b_t)
      hang();
  endtask : axi_wr

  task automatic axi_rd(input logic [16:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ar_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar_t = 0;
    r_t = 0;
    n = 0;
    while (!r_t && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (!ar_t && s_axi_arready === 1'b1)
      begin
        ar_t = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1)
      begin
        r_t = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!r_t)
      hang();
  endtask : axi_rd

  function automatic logic [31:0] cfg_word(int run, int dith, int sel, int rate);
    return 32'((rate << 12) | (sel << 8) | (dith << 1) | run);
  endfunction : cfg_word

  // expected routing of the positive and negative legs
  function automatic logic [5:0] exp_mux(int sel);
    if (sel <= 3)
      return {4'(sel), 2'(sdac_pkg::NEG_HALF_VREF)};
    case (sel)
      4: return {4'(sdac_pkg::POS_PAD_QTR), 2'(sdac_pkg::NEG_HALF_VREF)};
      5: return {4'(sdac_pkg::POS_CORE_HALF), 2'(sdac_pkg::NEG_HALF_VREF)};
      7: return {4'(sdac_pkg::POS_GND), 2'(sdac_pkg::NEG_HALF_VREF)};
      8: return {4'(sdac_pkg::POS_VREF), 2'(sdac_pkg::NEG_HALF_VREF)};
      9: return {4'(sdac_pkg::POS_IN0), 2'(sdac_pkg::NEG_IN1)};
      10: return {4'(sdac_pkg::POS_IN2), 2'(sdac_pkg::NEG_IN3)};
      default: return {4'(sdac_pkg::POS_NONE), 2'(sdac_pkg::NEG_NONE)};
    endcase
  endfunction : exp_mux

  // result model: ones over the period, clipped to the field, left aligned
  function automatic int model_res(int ones, int r);
    int full;
    full = (1 << (5 + r)) - 1;
    if (ones > full)
      ones = full;
    return ones << (11 - r);
  endfunction : model_res

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= lim)
      hang();
  endtask : wait_irq

  // main sequence
  initial
  begin
    aresetn = 1'b0;
    mod_bit = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    void'($urandom(31743));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset state, read-only result word and unmapped places
    check(32'({conv_run, vref_out_en, irq, dither_off}), 32'h0);
    check(32'(mux), 32'(exp_mux(0)));
    axi_wr(A_DATA, 32'h0000FFFF, resp);
    check(32'(resp), 32'(sdac_pkg::RESP_OKAY));
    axi_rd(A_DATA, rd, resp);
    check(rd, 32'h0);
    axi_rd(17'h12404, rd, resp);
    check({rd[29:0], resp}, {30'h0, sdac_pkg::RESP_SLVERR});
    axi_wr(17'h1FFFC, 32'h1, resp);
    check(32'(resp), 32'(sdac_pkg::RESP_SLVERR));
    // every select code with run clear, dither toggled alongside
    for (int s = 0; s < 16; s++)
    begin
      axi_wr(A_CFG, cfg_word(0, s % 2, s, 0), resp);
      repeat (2) @(posedge aclk);
      if (s >= 4 && s <= 8)
        check(32'(mux.pos), 32'(exp_mux(s) >> 2));
      else
        check(32'(mux), 32'(exp_mux(s)));
      check(32'(dither_off), 32'(s % 2));
      axi_rd(A_CFG, rd, resp);
      check(rd, cfg_word(0, s % 2, s, 0));
    end
    // free-running conversions at rates 0 to 3, mask set
    axi_wr(A_MASK, 32'h1, resp);
    for (int r = 0; r < 4; r++)
    begin
      // the two slower rates always run full scale to reach the clipping path
      mb = (r >= 2) ? 1 : $urandom % 2;
      mod_bit <= mb[0];
      per = (32 << r) * 20;
      axi_wr(A_CFG, cfg_word(1, 0, 0, r), resp);
      @(posedge aclk);
      check(32'({conv_run, vref_out_en}), 32'h3);
      for (int k = 0; k < 3; k++)
      begin
        wait_irq(per + 200);
        axi_rd(A_FLAG, rd, resp);
        check(rd, 32'h1);
        axi_rd(A_DATA, rd, resp);
        res_q.push_back(model_res(mb * (32 << r), r));
        // the first result after start is discarded
        if (k > 0)
          check(rd, 32'(res_q[$]));
        axi_wr(A_FLAG, 32'h1, resp);
        @(posedge aclk);
        check(32'(irq), 32'h0);
      end
      check(32'(gap), 32'(per));
      axi_wr(A_CFG, cfg_word(0, 0, 0, r), resp);
      @(posedge aclk);
      check(32'({conv_run, vref_out_en}), 32'h0);
      r0 = rises;
      repeat (per + 100) @(posedge aclk);
      check(32'(rises), 32'(r0));
      axi_rd(A_DATA, rd, resp);
      check(rd, 32'(res_q[$]));
    end
    // masked completion sets the flag but keeps the line low
    axi_wr(A_MASK, 32'h0, resp);
    axi_wr(A_CFG, cfg_word(1, 0, 1, 0), resp);
    r0 = 0;
    repeat (1400)
    begin
      @(posedge aclk);
      if (irq !== 1'b0)
        r0++;
    end
    check(32'(r0), 32'h0);
    axi_rd(A_FLAG, rd, resp);
    check(rd, 32'h1);
    axi_wr(A_MASK, 32'h1, resp);
    @(posedge aclk);
    check(32'(irq), 32'h1);
    axi_wr(A_CFG, cfg_word(0, 0, 1, 0), resp);
    final_report();
  end
endmodule : tb_top
